// ==== core/mdls_pkg.sv ====
// mdls_pkg.sv: constants, tables and types shared by both ends of the latency-sync link
// How it works
// - device measures data-to-sample clock delay as code
// - twenty codes, 0.2-cycle bins, fixed order
// - automatic phase select follows code group
// - host advances select only in late bins
// - data clock skew below 0.4 sample cycles
// - host flags delay gap above 0.4 cycles
// - late converter gets manual mode, adjusted select
// - control write 0x04 sets manual, select 00
// - manual flag bit 2, select bits 1:0
// - adjusted select cuts latency by one cycle
// - host re-reads phase code periodically while its monitor is enabled
package mdls_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // serial configuration port register map
  localparam logic [6:0] REG_SYNC_CONTROL = 7'h05;
  localparam logic [6:0] REG_SYNC_PHASE_STATUS = 7'h06;
  localparam int MANUAL_BIT = 2;
  localparam logic [2:0] SYNC_CONTROL_RESET = 3'h0;
  localparam logic [7:0] PHASE_STATUS_RESET = 8'h03;
  // one sample clock cycle is five mclk cycles, so one mclk cycle is one 0.2 bin
  localparam logic [2:0] SAMPLE_DIV_LAST = 3'h4;
  localparam logic [4:0] BINS_PER_CYCLE = 5'h05;
  localparam int NUM_CODES = 20;
  localparam logic [4:0] NO_CODE = 5'h14;
  localparam logic [7:0] PH_CODE [0:19] = '{
    8'h03, 8'h04, 8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h54, 8'h53,
    8'h52, 8'h51, 8'h50, 8'h40, 8'h30, 8'h20, 8'h10, 8'h00, 8'h01, 8'h02};
  // default select per group; the next entry is the one-cycle-shorter select
  localparam logic [1:0] PS_BY_GROUP [0:3] = '{2'b10, 2'b00, 2'b01, 2'b11};
  localparam logic [1:0] BASE_LAT = 2'h2;
  localparam logic [2:0] LATE_BIN_MIN = 3'h3;
  localparam logic [3:0] SKEW_BINS = 4'h2;
  // link timing in mclk cycles
  localparam logic [4:0] DCLK_HALF_LAST = 5'h09;
  localparam logic [3:0] SCK_HALF_LAST = 4'h7;
  localparam logic [35:0] DEV_SYNC_RESET = 36'h200000000;
  // host monitor interval
  localparam int MON_PERIOD_US = 100;
  localparam int MON_CYCLES = MON_PERIOD_US * 1000 / CLK_PERIOD_NS;
  // host APB map
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_CFG = 8'h04;
  localparam logic [7:0] HREG_STAT = 8'h08;
  localparam int CMD_ALIGN_BIT = 16;
  localparam int CMD_READ_BIT = 15;

  typedef enum logic [2:0] {H_IDLE, H_RAW, H_RDPH, H_DECIDE, H_WRCTL} mdls_host_state_type;
  typedef enum logic [1:0] {SM_IDLE, SM_RUN, SM_GAP} mdls_spi_state_type;

  function automatic logic [4:0] code_index(input logic [7:0] code);
    logic [4:0] idx;
    idx = NO_CODE;
    for (int i = 0; i < NUM_CODES; i++) begin
      if (PH_CODE[i] == code) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : code_index

  function automatic logic [1:0] ps_rank(input logic [1:0] ps);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (PS_BY_GROUP[i] == ps) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : ps_rank
endpackage : mdls_pkg

// ==== core/mdls_if.sv ====
// mdls_if.sv: data clock, data ports and serial configuration pins between source and converter
interface mdls_if;
  logic dataClockIn;
  logic [15:0] dataPortA;
  logic [15:0] dataPortB;
  logic cfgCsN;
  logic cfgSck;
  logic cfgSdi;
  logic cfgSdo;
  modport dev (
    input dataClockIn, dataPortA, dataPortB, cfgCsN, cfgSck, cfgSdi,
    output cfgSdo
  );
  modport host (
    output dataClockIn, dataPortA, dataPortB, cfgCsN, cfgSck, cfgSdi,
    input cfgSdo
  );
endinterface : mdls_if

// ==== core/mdls_spi_master.sv ====
// mdls_spi_master.sv: serial port master issuing one 16-bit register access at a time
module mdls_spi_master (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic start, // start one access, taken only when idle
  input wire logic rd, // 1 read, 0 write
  input wire logic [6:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  output logic done, // pulse when access and gap are over
  output logic [7:0] rdata, // read data of last access
  output logic csN, // chip select, active low
  output logic sck, // serial clock
  output logic sdi, // serial data to device
  input wire logic sdo // serial data from device
);
  mdls_pkg::mdls_spi_state_type state_r, state_nxt;
  logic sdoMeta_r, sdoSync_r;
  logic [3:0] halfCnt_r, halfCnt_nxt;
  logic [3:0] bitIdx_r, bitIdx_nxt;
  logic [15:0] shOut_r, shOut_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic csN_r, csN_nxt;
  logic sck_r, sck_nxt;
  logic halfTick;

  always_comb begin
    state_nxt = state_r;
    halfCnt_nxt = halfCnt_r + 4'h1;
    bitIdx_nxt = bitIdx_r;
    shOut_nxt = shOut_r;
    rdata_nxt = rdata_r;
    csN_nxt = csN_r;
    sck_nxt = sck_r;
    done = 1'b0;
    halfTick = (halfCnt_r == mdls_pkg::SCK_HALF_LAST);
    if (halfTick) begin
      halfCnt_nxt = 4'h0;
    end
    case (state_r)
      mdls_pkg::SM_IDLE: begin
        halfCnt_nxt = 4'h0;
        if (start) begin
          shOut_nxt = {rd, addr, wdata};
          csN_nxt = 1'b0;
          bitIdx_nxt = 4'h0;
          state_nxt = mdls_pkg::SM_RUN;
        end
      end
      mdls_pkg::SM_RUN: begin
        if (halfTick && !sck_r) begin
          sck_nxt = 1'b1;
          if (bitIdx_r[3]) begin
            rdata_nxt = {rdata_r[6:0], sdoSync_r};
          end
        end else if (halfTick) begin
          sck_nxt = 1'b0;
          shOut_nxt = {shOut_r[14:0], 1'b0};
          bitIdx_nxt = bitIdx_r + 4'h1;
          if (bitIdx_r == 4'hF) begin
            csN_nxt = 1'b1;
            state_nxt = mdls_pkg::SM_GAP;
          end
        end
      end
      mdls_pkg::SM_GAP: begin
        // select stays high long enough for the device synchroniser to see it
        if (halfTick) begin
          done = 1'b1;
          state_nxt = mdls_pkg::SM_IDLE;
        end
      end
      default: state_nxt = mdls_pkg::SM_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= mdls_pkg::SM_IDLE;
      sdoMeta_r <= 1'b0;
      sdoSync_r <= 1'b0;
      halfCnt_r <= 4'h0;
      bitIdx_r <= 4'h0;
      shOut_r <= 16'h0000;
      rdata_r <= 8'h00;
      csN_r <= 1'b1;
      sck_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sdoMeta_r <= sdo;
      sdoSync_r <= sdoMeta_r;
      halfCnt_r <= halfCnt_nxt;
      bitIdx_r <= bitIdx_nxt;
      shOut_r <= shOut_nxt;
      rdata_r <= rdata_nxt;
      csN_r <= csN_nxt;
      sck_r <= sck_nxt;
    end
  end

  assign rdata = rdata_r;
  assign csN = csN_r;
  assign sck = sck_r;
  assign sdi = shOut_r[15];
endmodule : mdls_spi_master

// ==== core/mdls_device.sv ====
// mdls_device.sv: converter end: phase comparator, synchronizer latency and serial registers
module mdls_device (
  input wire logic mclk, // system clock, also the sample clock source
  input wire logic rst, // async reset, active high
  mdls_if.dev link, // link from the data source
  output logic [31:0] dacOut, // {port B, port A} word leaving the synchronizer
  output logic sampleTick, // one-cycle sample clock enable
  output logic manualSyncFlag, // manual mode in force
  output logic [1:0] phaseSelect // phase select in force
);
  logic [35:0] meta_r, sync_r;
  logic dClkPrev_r, sckPrev_r;
  logic dRise, sRise, sFall, csNS;
  logic [2:0] divCnt_r, divCnt_nxt;
  logic [1:0] quad_r, quad_nxt;
  logic [1:0] group_r, group_nxt;
  logic [7:0] phaseCode_r, phaseCode_nxt;
  logic [31:0] word_r, word_nxt;
  logic [31:0] dl_r [0:3];
  logic [31:0] dl_nxt [0:3];
  logic [31:0] dacOut_r, dacOut_nxt;
  logic [4:0] measIdx;
  logic [1:0] defPs, effPs, shift, lat;
  logic [4:0] bitCnt_r, bitCnt_nxt;
  logic [14:0] shIn_r, shIn_nxt;
  logic [7:0] rdShift_r, rdShift_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [15:0] frame;
  logic [7:0] regRead;

  // every pin passes two flops; data and clock share the same delay
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= mdls_pkg::DEV_SYNC_RESET;
      sync_r <= mdls_pkg::DEV_SYNC_RESET;
      dClkPrev_r <= 1'b0;
      sckPrev_r <= 1'b0;
    end else begin
      meta_r <= {link.cfgSdi, link.cfgSck, link.cfgCsN, link.dataClockIn,
                 link.dataPortB, link.dataPortA};
      sync_r <= meta_r;
      dClkPrev_r <= sync_r[32];
      sckPrev_r <= sync_r[34];
    end
  end

  always_comb begin
    dRise = sync_r[32] & ~dClkPrev_r;
    csNS = sync_r[33];
    sRise = sync_r[34] & ~sckPrev_r;
    sFall = ~sync_r[34] & sckPrev_r;
  end

  // phase comparator and synchronizer
  always_comb begin
    sampleTick = (divCnt_r == mdls_pkg::SAMPLE_DIV_LAST);
    divCnt_nxt = sampleTick ? 3'h0 : divCnt_r + 3'h1;
    // counts down so a data clock one bin later steps the code back by one
    quad_nxt = sampleTick ? quad_r - 2'h1 : quad_r;
    group_nxt = group_r;
    phaseCode_nxt = phaseCode_r;
    word_nxt = word_r;
    // bins left until the next sample edge, plus which sample cycle of four
    measIdx = {3'h0, quad_r} * mdls_pkg::BINS_PER_CYCLE
            + {2'h0, mdls_pkg::SAMPLE_DIV_LAST - divCnt_r};
    if (dRise) begin
      phaseCode_nxt = mdls_pkg::PH_CODE[measIdx];
      group_nxt = quad_r;
      word_nxt = sync_r[31:0];
    end
    defPs = mdls_pkg::PS_BY_GROUP[group_r];
    effPs = ctrl_r[mdls_pkg::MANUAL_BIT] ? ctrl_r[1:0] : defPs;
    shift = mdls_pkg::ps_rank(effPs) - mdls_pkg::ps_rank(defPs);
    // one step ahead saves a cycle; three steps is the same as one step back
    if (shift == 2'h1) begin
      lat = mdls_pkg::BASE_LAT - 2'h1;
    end else if (shift == 2'h3) begin
      lat = mdls_pkg::BASE_LAT + 2'h1;
    end else begin
      lat = mdls_pkg::BASE_LAT;
    end
    dl_nxt = dl_r;
    dacOut_nxt = dacOut_r;
    if (sampleTick) begin
      dl_nxt[0] = word_r;
      for (int i = 1; i < 4; i++) begin
        dl_nxt[i] = dl_r[i - 1];
      end
      dacOut_nxt = dl_r[lat];
    end
  end

  // serial register port: 16-bit frames, read flag, 7-bit address, 8-bit data
  always_comb begin
    frame = {shIn_r, sync_r[35]};
    bitCnt_nxt = bitCnt_r;
    shIn_nxt = shIn_r;
    rdShift_nxt = rdShift_r;
    ctrl_nxt = ctrl_r;
    if (frame[6:0] == mdls_pkg::REG_SYNC_CONTROL) begin
      regRead = {5'h00, ctrl_r};
    end else if (frame[6:0] == mdls_pkg::REG_SYNC_PHASE_STATUS) begin
      regRead = phaseCode_r;
    end else begin
      regRead = 8'h00;
    end
    if (csNS) begin
      bitCnt_nxt = 5'h00;
      rdShift_nxt = 8'h00;
    end else if (sRise) begin
      shIn_nxt = frame[14:0];
      bitCnt_nxt = bitCnt_r + 5'h01;
      if (bitCnt_r == 5'h07 && frame[7]) begin
        rdShift_nxt = regRead;
      end
      if (bitCnt_r == 5'h0F && !frame[15] && frame[14:8] == mdls_pkg::REG_SYNC_CONTROL) begin
        ctrl_nxt = frame[2:0];
      end
    end else if (sFall && bitCnt_r >= 5'h09) begin
      rdShift_nxt = {rdShift_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_r <= 3'h0;
      quad_r <= 2'h0;
      group_r <= 2'h0;
      phaseCode_r <= mdls_pkg::PHASE_STATUS_RESET;
      word_r <= 32'h00000000;
      for (int i = 0; i < 4; i++) begin
        dl_r[i] <= 32'h00000000;
      end
      dacOut_r <= 32'h00000000;
      bitCnt_r <= 5'h00;
      shIn_r <= 15'h0000;
      rdShift_r <= 8'h00;
      ctrl_r <= mdls_pkg::SYNC_CONTROL_RESET;
    end else begin
      divCnt_r <= divCnt_nxt;
      quad_r <= quad_nxt;
      group_r <= group_nxt;
      phaseCode_r <= phaseCode_nxt;
      word_r <= word_nxt;
      dl_r <= dl_nxt;
      dacOut_r <= dacOut_nxt;
      bitCnt_r <= bitCnt_nxt;
      shIn_r <= shIn_nxt;
      rdShift_r <= rdShift_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign dacOut = dacOut_r;
  assign manualSyncFlag = ctrl_r[mdls_pkg::MANUAL_BIT];
  assign phaseSelect = effPs;
  assign link.cfgSdo = rdShift_r[7];
endmodule : mdls_device

// ==== core/mdls_host.sv ====
// mdls_host.sv: data source and host controller end, ordered over APB
module mdls_host #(
  parameter int MON_CYCLES = mdls_pkg::MON_CYCLES // mclk cycles between monitor re-reads
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always high
  output logic pslverr, // APB error on unmapped address
  input wire logic [15:0] sampleA, // next port A sample
  input wire logic [15:0] sampleB, // next port B sample
  output logic sampleTake, // pulse: sample pair taken
  mdls_if.host link // link to the converter
);
  mdls_pkg::mdls_host_state_type state_r, state_nxt;
  logic [4:0] dCnt_r, dCnt_nxt;
  logic dClk_r, dClk_nxt;
  logic [31:0] data_r, data_nxt;
  logic [7:0] lastRd_r, lastRd_nxt;
  logic [7:0] lastPh_r, lastPh_nxt;
  logic [2:0] refBin_r, refBin_nxt;
  logic monEn_r, monEn_nxt;
  logic late_r, late_nxt;
  logic [31:0] monCnt_r, monCnt_nxt;
  logic apbWr, busy;
  logic spiStart, spiRd, spiDone;
  logic [6:0] spiAddr;
  logic [7:0] spiWdata, spiRdata;
  logic [4:0] phIdx;
  logic [2:0] phBin;
  logic [1:0] phGrp, adjPs;
  logic lateNow;

  // data clock by divider, one period spans four sample cycles
  always_comb begin
    dCnt_nxt = dCnt_r + 5'h01;
    dClk_nxt = dClk_r;
    data_nxt = data_r;
    sampleTake = 1'b0;
    if (dCnt_r == mdls_pkg::DCLK_HALF_LAST) begin
      dCnt_nxt = 5'h00;
      dClk_nxt = ~dClk_r;
      // data changes with the rising edge; skew against other sources is a board matter
      if (!dClk_r) begin
        data_nxt = {sampleB, sampleA};
        sampleTake = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dCnt_r <= 5'h00;
      dClk_r <= 1'b0;
      data_r <= 32'h00000000;
    end else begin
      dCnt_r <= dCnt_nxt;
      dClk_r <= dClk_nxt;
      data_r <= data_nxt;
    end
  end

  // decode the phase code into a bin within the cycle and a group
  always_comb begin
    phIdx = mdls_pkg::code_index(lastPh_r);
    phBin = 3'(phIdx % mdls_pkg::BINS_PER_CYCLE);
    phGrp = 2'(phIdx / mdls_pkg::BINS_PER_CYCLE);
    adjPs = mdls_pkg::PS_BY_GROUP[phGrp + 2'h1];
    // bins are compared by lower edge, so a gap above two bins is over 0.4 cycles
    lateNow = (phIdx < mdls_pkg::NO_CODE)
            && (phBin >= mdls_pkg::LATE_BIN_MIN)
            && ({1'b0, phBin} > ({1'b0, refBin_r} + mdls_pkg::SKEW_BINS));
  end

  assign apbWr = psel & penable & pwrite;
  assign busy = (state_r != mdls_pkg::H_IDLE);

  always_comb begin
    state_nxt = state_r;
    lastRd_nxt = lastRd_r;
    lastPh_nxt = lastPh_r;
    refBin_nxt = refBin_r;
    monEn_nxt = monEn_r;
    late_nxt = late_r;
    monCnt_nxt = monCnt_r;
    spiStart = 1'b0;
    spiRd = 1'b1;
    spiAddr = mdls_pkg::REG_SYNC_PHASE_STATUS;
    spiWdata = 8'h00;
    if (apbWr && paddr == mdls_pkg::HREG_CFG) begin
      monEn_nxt = pwdata[0];
      refBin_nxt = pwdata[10:8];
    end
    case (state_r)
      mdls_pkg::H_IDLE: begin
        monCnt_nxt = monEn_r ? monCnt_r + 32'h00000001 : 32'h00000000;
        // a command while busy never reaches here and is dropped
        if (apbWr && paddr == mdls_pkg::HREG_CMD) begin
          spiStart = 1'b1;
          if (pwdata[mdls_pkg::CMD_ALIGN_BIT]) begin
            state_nxt = mdls_pkg::H_RDPH;
          end else begin
            spiRd = pwdata[mdls_pkg::CMD_READ_BIT];
            spiAddr = pwdata[14:8];
            spiWdata = pwdata[7:0];
            state_nxt = mdls_pkg::H_RAW;
          end
        end else if (monEn_r && monCnt_r >= 32'(MON_CYCLES - 1)) begin
          spiStart = 1'b1;
          monCnt_nxt = 32'h00000000;
          state_nxt = mdls_pkg::H_RDPH;
        end
      end
      mdls_pkg::H_RAW: begin
        if (spiDone) begin
          lastRd_nxt = spiRdata;
          state_nxt = mdls_pkg::H_IDLE;
        end
      end
      mdls_pkg::H_RDPH: begin
        if (spiDone) begin
          lastPh_nxt = spiRdata;
          state_nxt = mdls_pkg::H_DECIDE;
        end
      end
      mdls_pkg::H_DECIDE: begin
        late_nxt = lateNow;
        if (lateNow) begin
          spiStart = 1'b1;
          spiRd = 1'b0;
          spiAddr = mdls_pkg::REG_SYNC_CONTROL;
          spiWdata = {5'h00, 1'b1, adjPs};
          state_nxt = mdls_pkg::H_WRCTL;
        end else begin
          // not late: leave the converter's settings alone
          state_nxt = mdls_pkg::H_IDLE;
        end
      end
      mdls_pkg::H_WRCTL: begin
        if (spiDone) begin
          state_nxt = mdls_pkg::H_IDLE;
        end
      end
      default: state_nxt = mdls_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= mdls_pkg::H_IDLE;
      lastRd_r <= 8'h00;
      lastPh_r <= 8'h00;
      refBin_r <= 3'h0;
      monEn_r <= 1'b0;
      late_r <= 1'b0;
      monCnt_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      lastRd_r <= lastRd_nxt;
      lastPh_r <= lastPh_nxt;
      refBin_r <= refBin_nxt;
      monEn_r <= monEn_nxt;
      late_r <= late_nxt;
      monCnt_r <= monCnt_nxt;
    end
  end

  // zero-wait APB slave
  always_comb begin
    pready = 1'b1;
    pslverr = 1'b0;
    prdata = 32'h00000000;
    if (psel) begin
      case (paddr)
        mdls_pkg::HREG_CMD: prdata = 32'h00000000;
        mdls_pkg::HREG_CFG: prdata = {21'h000000, refBin_r, 7'h00, monEn_r};
        mdls_pkg::HREG_STAT: prdata = {8'h00, lastPh_r, lastRd_r, 6'h00, late_r, busy};
        default: pslverr = penable;
      endcase
    end
  end

  mdls_spi_master u_spi (
    .mclk(mclk),
    .rst(rst),
    .start(spiStart),
    .rd(spiRd),
    .addr(spiAddr),
    .wdata(spiWdata),
    .done(spiDone),
    .rdata(spiRdata),
    .csN(link.cfgCsN),
    .sck(link.cfgSck),
    .sdi(link.cfgSdi),
    .sdo(link.cfgSdo)
  );

  assign link.dataClockIn = dClk_r;
  assign link.dataPortA = data_r[15:0];
  assign link.dataPortB = data_r[31:16];
endmodule : mdls_host

// ==== tb/mdls_link_asserts.sv ====
// mdls_link_asserts.sv: timing checks on the link between data source and converter
module mdls_link_asserts (
  input wire logic mclk, // system clock
  input wire logic rst, // host end reset, active high
  input wire logic dataClockIn, // data clock
  input wire logic [15:0] dataPortA, // port A word
  input wire logic [15:0] dataPortB, // port B word
  input wire logic cfgCsN, // serial select, active low
  input wire logic cfgSck, // serial clock
  input wire logic cfgSdi, // serial data to converter
  input wire logic cfgSdo // serial data from converter
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lowCnt_r, lowCnt_nxt;
  logic [4:0] riseCnt_r, riseCnt_nxt;
  logic sckPrev_r, sckPrev_nxt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  always_comb begin
    sckPrev_nxt = cfgSck;
    lowCnt_nxt = cfgCsN ? 16'h0000 : lowCnt_r + 16'h0001;
    riseCnt_nxt = cfgCsN ? 5'h00 : riseCnt_r + 5'(cfgSck & ~sckPrev_r);
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sckPrev_r <= 1'b0;
      lowCnt_r <= 16'h0000;
      riseCnt_r <= 5'h00;
    end else begin
      sckPrev_r <= sckPrev_nxt;
      lowCnt_r <= lowCnt_nxt;
      riseCnt_r <= riseCnt_nxt;
    end
  end
  a_sck_idle: assert property (cfgCsN |-> !cfgSck)
    else $error("serial clock moved outside a frame");
  a_frame_length: assert property ($rose(cfgCsN) |-> lowCnt_r == 16'h0100)
    else $error("select low time is not 256 cycles");
  a_frame_bits: assert property ($rose(cfgCsN) |-> riseCnt_r == 5'h10)
    else $error("frame does not carry 16 clock rises");
  a_cs_gap: assert property ($rose(cfgCsN) |-> cfgCsN[*8])
    else $error("accesses not separated by the gap");
  // the converter needs a few cycles to see select go high
  a_sdo_quiet: assert property (cfgCsN[*5] |-> !cfgSdo)
    else $error("return data driven outside a read");
  a_sck_half: assert property ($rose(cfgSck) |-> cfgSck[*8] ##1 !cfgSck)
    else $error("serial clock high phase not 8 cycles");
  a_sdi_stable: assert property (!cfgCsN && cfgSck && $past(cfgSck) |-> $stable(cfgSdi))
    else $error("serial data moved while clock high");
  a_dclk_high: assert property ($rose(dataClockIn) |-> dataClockIn[*8] ##1
    dataClockIn[*2] ##1 !dataClockIn)
    else $error("data clock high phase not 10 cycles");
  a_dclk_low: assert property ($fell(dataClockIn) |-> !dataClockIn[*8] ##1
    !dataClockIn[*2] ##1 dataClockIn)
    else $error("data clock low phase not 10 cycles");
  a_data_on_rise: assert property (!$stable({dataPortB, dataPortA}) |-> $rose(dataClockIn))
    else $error("data word changed away from a data clock rise");
endmodule : mdls_link_asserts

// ==== tb/tb_multi_dac_latency_sync.sv ====
// tb_multi_dac_latency_sync.sv: self-checking bench for the host and converter ends
module tb_multi_dac_latency_sync;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstDev, rstHost, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dacOut;
  logic [15:0] sampleA, sampleB;
  logic sampleTake, sampleTick, manualSyncFlag;
  logic [1:0] phaseSelect;
  int failCount, totalChecks;
  int kOfIdx [0:19];
  mdls_if linkIf();
  mdls_host #(.MON_CYCLES(400)) mdls_host_inst (.mclk(mclk), .rst(rstHost), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sampleA(sampleA), .sampleB(sampleB),
    .sampleTake(sampleTake), .link(linkIf));
  mdls_device mdls_device_inst (.mclk(mclk), .rst(rstDev), .link(linkIf), .dacOut(dacOut),
    .sampleTick(sampleTick), .manualSyncFlag(manualSyncFlag), .phaseSelect(phaseSelect));
  mdls_link_asserts mdls_link_asserts_inst (.mclk(mclk), .rst(rstHost),
    .dataClockIn(linkIf.dataClockIn), .dataPortA(linkIf.dataPortA),
    .dataPortB(linkIf.dataPortB), .cfgCsN(linkIf.cfgCsN), .cfgSck(linkIf.cfgSck),
    .cfgSdi(linkIf.cfgSdi), .cfgSdo(linkIf.cfgSdo));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // fresh random word after every take, so each word is unique at the output
  always @(posedge mclk) begin
    if (sampleTake === 1'b1) begin
      sampleA <= 16'($urandom);
      sampleB <= 16'($urandom);
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic ok, input string msg);
    totalChecks++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, "no ready");
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic idle(output logic [31:0] s);
    int n;
    logic e;
    n = 0;
    do begin
      apb(1'b0, mdls_pkg::HREG_STAT, 32'h00000000, s, e);
      n++;
    end while (s[0] !== 1'b0 && n < 400);
    chk(n < 400, "host stayed busy");
  endtask : idle
  task automatic dev(input logic rd, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] r;
    logic e;
    apb(1'b1, mdls_pkg::HREG_CMD, {16'h0000, rd, a, d}, r, e);
    idle(r);
    q = r[15:8];
  endtask : dev
  // host released k cycles after the converter shifts the data clock phase by k
  task automatic restart(input int k);
    rstDev <= 1'b1;
    rstHost <= 1'b1;
    repeat (5) @(posedge mclk);
    rstDev <= 1'b0;
    repeat (k) @(posedge mclk);
    rstHost <= 1'b0;
    repeat (80) @(posedge mclk);
  endtask : restart
  task automatic meas(output int d);
    logic [31:0] w;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (sampleTake !== 1'b1 && n < 100);
    chk(n < 100, "no sample taken");
    w = {sampleB, sampleA};
    d = 0;
    while (dacOut !== w && d < 100) begin
      @(posedge mclk);
      d++;
    end
    chk(d < 100, "word never reached the output");
  endtask : meas
  function automatic int lookup(input logic [7:0] c);
    lookup = 20;
    for (int j = 0; j < 20; j++) begin
      if (mdls_pkg::PH_CODE[j] === c) lookup = j;
    end
  endfunction : lookup
  initial begin
    // about twice the expected length of the whole run
    #600000;
    failCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    int idx [0:19];
    int cases [0:5] = '{2, 3, 4, 9, 14, 19};
    int b, g, ex, d0, d1;
    logic [7:0] q, v;
    logic [31:0] s;
    logic e;
    logic [1:0] exPs;
    rstDev = 1'b1;
    rstHost = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sampleA = 16'h0000;
    sampleB = 16'h0000;
    void'($urandom(88643));
    for (int i = 0; i < 20; i++) begin
      restart(i);
      if (i == 0) begin
        dev(1'b1, mdls_pkg::REG_SYNC_CONTROL, 8'h00, q);
        chk(q === 8'h00, "control not clear after reset");
      end
      dev(1'b1, mdls_pkg::REG_SYNC_PHASE_STATUS, 8'h00, q);
      idx[i] = lookup(q);
      chk(idx[i] < 20, "phase code outside the table");
      exPs = mdls_pkg::PS_BY_GROUP[idx[i] / 5];
      chk(manualSyncFlag === 1'b0 && phaseSelect === exPs, "default select");
      if (idx[i] < 20) kOfIdx[idx[i]] = i;
      if (i > 0) begin
        b = (idx[i] - idx[i - 1] + 20) % 20;
        chk(b == (idx[1] - idx[0] + 20) % 20 && (b == 1 || b == 19), "code order");
      end
    end
    $display("test phase readout done");
    foreach (cases[c]) begin
      restart(kOfIdx[cases[c]]);
      b = cases[c] % 5;
      g = cases[c] / 5;
      for (int r = 0; r < 3; r++) begin
        ex = (b >= 3 && b > r + 2);
        exPs = mdls_pkg::PS_BY_GROUP[(ex != 0) ? (g + 1) % 4 : g];
        dev(1'b0, mdls_pkg::REG_SYNC_CONTROL, 8'h00, q);
        apb(1'b1, mdls_pkg::HREG_CFG, 32'(r) << 8, s, e);
        apb(1'b0, mdls_pkg::HREG_CFG, 32'h00000000, s, e);
        chk(s === 32'(r) << 8, "reference bin read back");
        apb(1'b1, mdls_pkg::HREG_CMD, 32'h00010000, s, e);
        idle(s);
        chk(s[23:16] === mdls_pkg::PH_CODE[cases[c]], "code seen by align");
        chk(s[1] === 1'(ex), "late decision");
        chk(manualSyncFlag === 1'(ex) && phaseSelect === exPs, "align result");
      end
    end
    $display("test align done");
    restart(kOfIdx[4]);
    b = 0;
    repeat (20) begin
      @(posedge mclk);
      b += int'(sampleTick);
    end
    chk(b == 4, "sample tick not once every five cycles");
    meas(d0);
    dev(1'b0, mdls_pkg::REG_SYNC_CONTROL, 8'h04, q);
    chk(manualSyncFlag === 1'b1 && phaseSelect === 2'b00, "write of 0x04");
    meas(d1);
    chk(d0 - d1 == 5, "latency not one sample cycle shorter");
    for (int t = 0; t < 6; t++) begin
      v = (t == 0) ? 8'h06 : 8'($urandom % 8);
      dev(1'b0, mdls_pkg::REG_SYNC_CONTROL, v, q);
      dev(1'b1, mdls_pkg::REG_SYNC_CONTROL, 8'h00, q);
      chk(q === v, "control read back");
      exPs = (v[2] === 1'b1) ? v[1:0] : 2'b10;
      chk(manualSyncFlag === v[2] && phaseSelect === exPs, "control fields");
    end
    dev(1'b0, mdls_pkg::REG_SYNC_PHASE_STATUS, 8'hFF, q);
    dev(1'b1, mdls_pkg::REG_SYNC_PHASE_STATUS, 8'h00, q);
    chk(q === mdls_pkg::PH_CODE[4], "status register was written");
    apb(1'b0, 8'h0C, 32'h00000000, s, e);
    chk(e === 1'b1 && s === 32'h00000000, "unmapped access not refused");
    $display("test registers done");
    dev(1'b0, mdls_pkg::REG_SYNC_CONTROL, 8'h00, q);
    apb(1'b1, mdls_pkg::HREG_CFG, 32'h00000001, s, e);
    d0 = 0;
    while (manualSyncFlag !== 1'b1 && d0 < 2000) begin
      @(posedge mclk);
      d0++;
    end
    chk(d0 < 2000 && phaseSelect === 2'b00, "monitor did not adjust");
    apb(1'b1, mdls_pkg::HREG_CFG, 32'h00000000, s, e);
    $display("test monitor done");
    tally_and_finish();
  end
endmodule : tb_multi_dac_latency_sync
